// file: logic/blp_controller.sv
// Backlight register port: two-wire controller end with command registers
`timescale 1ns/1ps
`default_nettype none
module blp_controller
    import blp_pkg::*;
#(
    parameter int QTR_CYC = SCL_QTR_CYC   // Clocks per quarter bit
)
(
    input  wire logic       clock,   // System clock
    input  wire logic       rst,     // Synchronous reset, active high
    blp_link_if.ctl         link,    // Two-wire bus
    input  wire logic [2:0] addr,    // Command register address
    input  wire logic [7:0] wdata,   // Write data
    input  wire logic       wr,      // Write strobe
    input  wire logic       rd,      // Read strobe
    output logic      [7:0] rdata_r  // Read data, cycle after rd
);

    generate
        if (QTR_CYC < 2 || QTR_CYC > 255)
            $error("QTR_CYC must be 2 to 255");
    endgenerate

    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

    typedef enum logic [3:0] {
        C_IDLE  = 4'b0001,
        C_START = 4'b0010,
        C_BITS  = 4'b0100,
        C_STOP  = 4'b1000
    } blp_cst_t;

    typedef struct packed {
        blp_cst_t   st;
        logic [7:0] qcnt;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [2:0] step;
        logic       rd_mode;
        logic       wbyte;
        logic [7:0] index;
        logic [7:0] wdata;
        logic [7:0] sh;
        logic [7:0] rx;
        logic       done;
        logic       nack;
        logic       scl;
        logic       sda;
        logic [1:0] sda_s;
        logic [7:0] rdata;
    } blp_ctl_t;

    // symbol program: {kind, byte} per step
    function automatic logic [9:0] step_op(input logic [2:0] step, input logic rd_mode,
                                           input logic [7:0] index, input logic [7:0] data);
        logic [9:0] op;
        op = {K_STOP, 8'h00};
        unique case (step)
            3'h0: op = {K_START, 8'h00};
            3'h1: op = {K_WBYTE, ADDR_WR};
            3'h2: op = {K_WBYTE, index};
            3'h3: op = rd_mode ? {K_START, 8'h00} : {K_WBYTE, data};
            3'h4: op = rd_mode ? {K_WBYTE, ADDR_RD} : {K_STOP, 8'h00};
            3'h5: op = rd_mode ? {K_RBYTE, 8'h00} : {K_STOP, 8'h00};
            default: op = {K_STOP, 8'h00};
        endcase
        return op;
    endfunction

    blp_ctl_t   c_r;
    blp_ctl_t   c_nxt;
    logic       adv;
    logic       tick;
    logic       smp;
    logic [2:0] nstep;
    logic [9:0] op;

    always_comb
    begin
        c_nxt       = c_r;
        adv         = 1'b0;
        nstep       = c_r.step + 3'h1;
        // Pin input through two flops
        c_nxt.sda_s = {c_r.sda_s[0], link.sda};
        smp         = c_r.sda_s[1];
        // Command registers; read data stands one cycle only
        c_nxt.rdata = 8'h00;
        if (rd)
        begin
            unique case (addr)
                CR_INDEX:  c_nxt.rdata = c_r.index;
                CR_WDATA:  c_nxt.rdata = c_r.wdata;
                CR_STATUS: c_nxt.rdata = {5'h00, c_r.done, c_r.nack, c_r.st != C_IDLE};
                CR_RDATA:  c_nxt.rdata = c_r.rx;
                default:   c_nxt.rdata = 8'h00;
            endcase
        end
        if (wr && addr == CR_INDEX)
            c_nxt.index = wdata;
        if (wr && addr == CR_WDATA)
            c_nxt.wdata = wdata;
        // Commands while busy are ignored
        if (wr && addr == CR_CMD && c_r.st == C_IDLE && (wdata[CMD_WR_BIT] || wdata[CMD_RD_BIT]))
        begin
            c_nxt.rd_mode = wdata[CMD_RD_BIT];
            c_nxt.done    = 1'b0;
            c_nxt.nack    = 1'b0;
            adv           = 1'b1;
            nstep         = 3'h0;
        end
        // Quarter-phase timer; the bus clock is divided from ours
        tick = (c_r.st != C_IDLE) && (c_r.qcnt == QTR_LAST);
        if (c_r.st != C_IDLE)
            c_nxt.qcnt = tick ? 8'h00 : c_r.qcnt + 8'h01;
        if (tick)
        begin
            c_nxt.ph = c_r.ph + 2'h1;
            unique case (c_r.st)
                C_START:
                begin
                    // raise data with clock low, drop it under high clock
                    if (c_r.ph == 2'h0)
                        c_nxt.sda = 1'b1;
                    if (c_r.ph == 2'h1)
                        c_nxt.scl = 1'b1;
                    if (c_r.ph == 2'h2)
                        c_nxt.sda = 1'b0;
                    if (c_r.ph == 2'h3)
                        adv = 1'b1;
                end
                C_STOP:
                begin
                    // pull data with clock low, release it under high clock
                    if (c_r.ph == 2'h0)
                        c_nxt.sda = 1'b0;
                    if (c_r.ph == 2'h1)
                        c_nxt.scl = 1'b1;
                    if (c_r.ph == 2'h2)
                        c_nxt.sda = 1'b1;
                    if (c_r.ph == 2'h3)
                    begin
                        c_nxt.st   = C_IDLE;
                        c_nxt.done = 1'b1;
                    end
                end
                C_BITS:
                begin
                    // data moves a quarter after the clock fall
                    // so a falling clock never races a data edge; ack slot and
                    // read bytes release the line, which also gives the NACK
                    if (c_r.ph == 2'h0)
                        c_nxt.sda = (c_r.wbyte && c_r.bitn <= LAST_DATA_BIT) ? c_r.sh[7] : 1'b1;
                    if (c_r.ph == 2'h1)
                        c_nxt.scl = 1'b1;
                    if (c_r.ph == 2'h3 && c_r.bitn < ACK_SLOT)
                    begin
                        c_nxt.sh   = {c_r.sh[6:0], smp};
                        c_nxt.bitn = c_r.bitn + 4'h1;
                        c_nxt.scl  = 1'b0;
                    end
                    else if (c_r.ph == 2'h3)
                    begin
                        adv = 1'b1;
                        if (!c_r.wbyte)
                            c_nxt.rx = c_r.sh;
                        if (c_r.wbyte && smp)
                        begin
                            c_nxt.nack = 1'b1;
                            nstep      = STEP_ABORT;
                        end
                    end
                end
                default:
                    c_nxt.ph = 2'h0;
            endcase
        end
        // Load next symbol with the clock low
        op = step_op(nstep, c_nxt.rd_mode, c_r.index, c_r.wdata);
        if (adv)
        begin
            c_nxt.step  = nstep;
            c_nxt.ph    = 2'h0;
            c_nxt.qcnt  = 8'h00;
            c_nxt.bitn  = 4'h0;
            c_nxt.sh    = op[7:0];
            c_nxt.scl   = 1'b0;
            c_nxt.wbyte = (op[9:8] == K_WBYTE);
            // Data is left alone here; each symbol sets it a quarter later
            unique case (op[9:8])
                K_START:          c_nxt.st = C_START;
                K_STOP:           c_nxt.st = C_STOP;
                K_WBYTE, K_RBYTE: c_nxt.st = C_BITS;
            endcase
        end
        if (rst)
        begin
            c_nxt       = '0;
            c_nxt.st    = C_IDLE;
            c_nxt.scl   = 1'b1;
            c_nxt.sda   = 1'b1;
            c_nxt.sda_s = 2'b11;
        end
    end

    // Single state register
    always_ff @(posedge clock)
    begin
        c_r <= c_nxt;
    end

    assign link.scl          = c_r.scl;
    assign link.ctl_sda_o    = 1'b0;
    assign link.ctl_sda_oe_n = c_r.sda;
    assign rdata_r           = c_r.rdata;

endmodule // blp_controller
`default_nettype wire

// file: logic/blp_link_if.sv
// Two-wire link between the controller and the target
`timescale 1ns/1ps
`default_nettype none
interface blp_link_if;
    logic scl;          // Clock line, made by the controller
    logic ctl_sda_o;    // Controller data value
    logic ctl_sda_oe_n; // Controller pulls data line when low
    logic dev_sda_o;    // Target data value
    logic dev_sda_oe_n; // Target pulls data line when low
    logic sda;          // Resolved data line

    // Wired-and with pull-up
    assign sda = (ctl_sda_oe_n ? 1'b1 : ctl_sda_o) & (dev_sda_oe_n ? 1'b1 : dev_sda_o);

    modport ctl (output scl, ctl_sda_o, ctl_sda_oe_n, input sda);
    modport dev (input scl, sda, output dev_sda_o, dev_sda_oe_n);
endinterface
`default_nettype wire

// file: logic/blp_pkg.sv
// Shared constants for the backlight two-wire register port
package blp_pkg;

    // Bus address of the target
    localparam logic [6:0] DEV_ADDR = 7'h38;
    localparam logic [7:0] ADDR_WR  = 8'h70;
    localparam logic [7:0] ADDR_RD  = 8'h71;

    // Byte framing: data bits, then the acknowledge slot
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT      = 4'h8;

    // Register map of the target
    localparam int NREG = 45;
    localparam logic [7:0] REG_OFS [NREG] = '{
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
        8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
        8'h27, 8'h28, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67,
        8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h79,
        8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E};
    localparam logic [7:0] REG_RST [NREG] = '{
        8'hE4, 8'hC0, 8'hC0, 8'h82, 8'h82, 8'h82, 8'hF1, 8'hF3, 8'hF1, 8'hF3,
        8'hF1, 8'hF3, 8'hFF, 8'hF8, 8'hE0, 8'hE0, 8'hE0, 8'h44, 8'hF0, 8'hF8,
        8'h00, 8'h00, 8'h35, 8'h33, 8'h6A, 8'h66, 8'hA1, 8'h99, 8'hDC, 8'hCC,
        8'h33, 8'h66, 8'h99, 8'hCC, 8'hFF, 8'h33, 8'h66, 8'h99, 8'hCC, 8'hFF,
        8'h33, 8'h66, 8'h99, 8'hCC, 8'hFF};
    localparam logic [7:0] OFS_ROUTING = 8'h10;
    localparam logic [7:0] OFS_ENABLES = 8'h1D;
    localparam logic [7:0] OFS_SAMPLE  = 8'h27;
    localparam logic [7:0] OFS_MEAN    = 8'h28;

    // Controller command registers
    localparam logic [2:0] CR_CMD    = 3'h0;
    localparam logic [2:0] CR_INDEX  = 3'h1;
    localparam logic [2:0] CR_WDATA  = 3'h2;
    localparam logic [2:0] CR_STATUS = 3'h3;
    localparam logic [2:0] CR_RDATA  = 3'h4;
    localparam int CMD_WR_BIT = 0;
    localparam int CMD_RD_BIT = 1;

    // Symbol kinds of a controller transfer
    localparam logic [1:0] K_START = 2'h0;
    localparam logic [1:0] K_WBYTE = 2'h1;
    localparam logic [1:0] K_RBYTE = 2'h2;
    localparam logic [1:0] K_STOP  = 2'h3;
    localparam logic [2:0] STEP_ABORT = 3'h7;

    // Link timing: one bit is four quarter phases
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 80;
    localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

endpackage

// file: logic/blp_target.sv
// Backlight register port: two-wire target end with its register file
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module blp_target
    import blp_pkg::*;
(
    input  wire logic       clock,      // System clock
    input  wire logic       rst,        // Reset, active high; synchronous on the system side, asynchronous on the link side
    blp_link_if.dev         link,       // Two-wire bus
    input  wire logic [7:0] sample_in,  // Live converter sample
    input  wire logic [7:0] mean_in,    // Averaged converter sample
    output logic      [7:0] routing_r,  // Sink routing register
    output logic      [7:0] enables_r,  // Bank enable register
    output logic      [7:0] wr_index_r, // Index of last finished write, dropped ones included
    output logic            wr_pulse_r, // One cycle per finished write, dropped ones included
    output logic            busy_r      // Bus between START and STOP
);

    typedef enum logic [4:0] {
        T_IDLE  = 5'b00001,
        T_ADDR  = 5'b00010,
        T_INDEX = 5'b00100,
        T_DATA  = 5'b01000,
        T_SEND  = 5'b10000
    } blp_tst_t;

    // Link-side state, clocked by the bus clock
    typedef struct packed {
        blp_tst_t   st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic       drive;
        logic       start_seen;
        logic [7:0] index;
        logic       idx_tog;
        logic       wr_tog;
        logic [7:0] wr_data;
    } blp_lnk_t;

    // System-side state
    typedef struct packed {
        logic [NREG-1:0][7:0] regs;
        logic [1:0]           wr_s;
        logic [1:0]           idx_s;
        logic [1:0]           sta_s;
        logic [1:0]           sto_s;
        logic                 wr_q;
        logic                 idx_q;
        logic                 sta_q;
        logic                 sto_q;
        logic [7:0]           rd_index;
        logic [7:0]           rd_word;
        logic                 busy;
        logic                 wr_pulse;
        logic [7:0]           wr_index;
    } blp_sys_t;

    // Map an offset to {hit, slot}
    function automatic logic [6:0] slot_of(input logic [7:0] ofs);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 0; i < NREG; i++)
        begin
            if (REG_OFS[i] == ofs)
            begin
                res = {1'b1, 6'(i)};
            end
        end
        return res;
    endfunction

    // Converter registers track live inputs, never written
    function automatic logic is_ro(input logic [7:0] ofs);
        return (ofs == OFS_SAMPLE) || (ofs == OFS_MEAN);
    endfunction

    localparam logic [6:0] ROUTE_HIT  = slot_of(OFS_ROUTING);
    localparam logic [6:0] ENABLE_HIT = slot_of(OFS_ENABLES);

    blp_lnk_t   l_r;
    blp_lnk_t   l_nxt;
    blp_sys_t   s_r;
    blp_sys_t   s_nxt;
    logic       start_tog;
    logic       stop_tog;
    logic       oe_n_r;
    logic [7:0] rx_byte;
    logic [6:0] wr_hit;
    logic [6:0] rd_hit;

    // START: data falls while clock high
    always_ff @(negedge link.sda or posedge rst)
    begin
        if (rst)
            start_tog <= 1'b0;
        else if (link.scl)
            start_tog <= ~start_tog;
    end

    // STOP: data rises while clock high
    always_ff @(posedge link.sda or posedge rst)
    begin
        if (rst)
            stop_tog <= 1'b0;
        else if (link.scl)
            stop_tog <= ~stop_tog;
    end

    // Bit engine on rising clock edges. The start toggle is read directly:
    // the first clock rise comes three quarters after START, so it has long settled.
    always_comb
    begin
        l_nxt = l_r;
        rx_byte = {l_r.sh[6:0], link.sda};
        if (start_tog != l_r.start_seen)
        begin
            // any START restarts the address byte
            l_nxt.start_seen = start_tog;
            l_nxt.st         = T_ADDR;
            l_nxt.sh         = rx_byte;
            l_nxt.bitn       = 4'h1;
            l_nxt.drive      = 1'b0;
        end
        else if (l_r.st != T_IDLE)
        begin
            l_nxt.bitn = l_r.bitn + 4'h1;
            if (l_r.st == T_SEND)
            begin
                if (l_r.bitn < ACK_SLOT)
                begin
                    // present next bit, release for ack slot
                    l_nxt.sh    = {l_r.sh[6:0], 1'b0};
                    l_nxt.drive = (l_r.bitn < LAST_DATA_BIT) ? ~l_r.sh[6] : 1'b0;
                end
                else if (link.sda)
                begin
                    l_nxt.st = T_IDLE;
                end
                else
                begin
                    l_nxt.bitn  = 4'h0;
                    l_nxt.sh    = s_r.rd_word;
                    l_nxt.drive = ~s_r.rd_word[7];
                end
            end
            else if (l_r.bitn < ACK_SLOT)
            begin
                l_nxt.sh = rx_byte;
                if (l_r.bitn == LAST_DATA_BIT)
                begin
                    if (l_r.st != T_ADDR || rx_byte[7:1] == DEV_ADDR)
                        l_nxt.drive = 1'b1;
                    else
                        l_nxt.st = T_IDLE;
                end
            end
            else
            begin
                l_nxt.bitn  = 4'h0;
                l_nxt.drive = 1'b0;
                unique case (l_r.st)
                    T_ADDR:
                    begin
                        // direction bit in the low position
                        if (l_r.sh[0])
                        begin
                            l_nxt.st    = T_SEND;
                            l_nxt.sh    = s_r.rd_word;
                            l_nxt.drive = ~s_r.rd_word[7];
                        end
                        else
                            l_nxt.st = T_INDEX;
                    end
                    T_INDEX:
                    begin
                        l_nxt.index   = l_r.sh;
                        l_nxt.idx_tog = ~l_r.idx_tog;
                        l_nxt.st      = T_DATA;
                    end
                    T_DATA:
                    begin
                        // data byte goes to the indexed register
                        l_nxt.wr_data = l_r.sh;
                        l_nxt.wr_tog  = ~l_r.wr_tog;
                    end
                    default:
                        l_nxt.st = T_IDLE;
                endcase
            end
        end
    end

    // Link state register; clock may stand still, so reset is asynchronous
    always_ff @(posedge link.scl or posedge rst)
    begin
        if (rst)
            l_r <= '{st: T_IDLE, default: '0};
        else
            l_r <= l_nxt;
    end

    // drive data only from the falling clock edge
    always_ff @(negedge link.scl or posedge rst)
    begin
        if (rst)
            oe_n_r <= 1'b1;
        else
            oe_n_r <= ~l_r.drive;
    end

    assign link.dev_sda_o    = 1'b0;
    assign link.dev_sda_oe_n = oe_n_r;

    // System side: toggles cross by two flops; index and data words are
    // held on the link side for a full byte, so they are stable when used.
    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.wr_s     = {s_r.wr_s[0], l_r.wr_tog};
        s_nxt.idx_s    = {s_r.idx_s[0], l_r.idx_tog};
        s_nxt.sta_s    = {s_r.sta_s[0], start_tog};
        s_nxt.sto_s    = {s_r.sto_s[0], stop_tog};
        s_nxt.wr_q     = s_r.wr_s[1];
        s_nxt.idx_q    = s_r.idx_s[1];
        s_nxt.sta_q    = s_r.sta_s[1];
        s_nxt.sto_q    = s_r.sto_s[1];
        s_nxt.wr_pulse = 1'b0;
        wr_hit         = slot_of(l_r.index);
        rd_hit         = slot_of(s_r.rd_index);
        // apply a finished write; unmapped or read-only is dropped
        if (s_r.wr_s[1] != s_r.wr_q)
        begin
            s_nxt.wr_pulse = 1'b1;
            s_nxt.wr_index = l_r.index;
            if (wr_hit[6] && !is_ro(l_r.index))
                s_nxt.regs[wr_hit[5:0]] = l_r.wr_data;
        end
        if (s_r.idx_s[1] != s_r.idx_q)
            s_nxt.rd_index = l_r.index;
        // Read word follows the index; unmapped reads as zero
        if (s_r.rd_index == OFS_SAMPLE)
            s_nxt.rd_word = sample_in;
        else if (s_r.rd_index == OFS_MEAN)
            s_nxt.rd_word = mean_in;
        else if (rd_hit[6])
            s_nxt.rd_word = s_r.regs[rd_hit[5:0]];
        else
            s_nxt.rd_word = 8'h00;
        // START wins over a STOP seen in the same cycle
        if (s_r.sta_s[1] != s_r.sta_q)
            s_nxt.busy = 1'b1;
        else if (s_r.sto_s[1] != s_r.sto_q)
            s_nxt.busy = 1'b0;
        if (rst)
        begin
            s_nxt = '0;
            for (int i = 0; i < NREG; i++)
            begin
                s_nxt.regs[i] = REG_RST[i];
            end
        end
    end

    // System state register
    always_ff @(posedge clock)
    begin
        s_r <= s_nxt;
    end

    assign routing_r  = s_r.regs[ROUTE_HIT[5:0]];
    assign enables_r  = s_r.regs[ENABLE_HIT[5:0]];
    assign wr_index_r = s_r.wr_index;
    assign wr_pulse_r = s_r.wr_pulse;
    assign busy_r     = s_r.busy;

endmodule // blp_target
`default_nettype wire

// file: testbench/blp_link_asserts.sv
// Checker watching the two-wire link between controller and target
`timescale 1ns/1ps
`default_nettype none
module blp_link_asserts
    import blp_pkg::*;
(
    input wire logic clock,        // System clock
    input wire logic rst,          // Synchronous reset
    input wire logic scl,          // Link clock
    input wire logic sda,          // Resolved data line
    input wire logic ctl_sda_oe_n, // Controller pull, low active
    input wire logic dev_sda_oe_n  // Target pull, low active
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic       first_r;
    // Bit count restarts on every START, so a repeated one counts too
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            bit_cnt_r <= 4'h0;
            first_r   <= 1'b0;
        end
        else if (scl && $past(scl) && $fell(sda))
        begin
            bit_cnt_r <= 4'h0;
            first_r   <= 1'b1;
        end
        else if ($rose(scl))
        begin
            bit_cnt_r <= (bit_cnt_r == ACK_SLOT) ? 4'h0 : bit_cnt_r + 4'h1;
            if (bit_cnt_r == ACK_SLOT)
                first_r <= 1'b0;
        end
    end
    // Shift only data bits, MSB arrives first
    always_ff @(posedge clock)
    begin
        if ($rose(scl) && bit_cnt_r <= LAST_DATA_BIT)
            shift_r <= {shift_r[6:0], sda};
    end
    a_addr_ack: assert property (($rose(scl) && first_r && bit_cnt_r == ACK_SLOT
        && shift_r[7:1] == DEV_ADDR) |-> !sda) else $error("address byte not acknowledged");
    a_dev_hold_bit: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
        else $error("target pull shorter than one bit");
    a_no_contention: assert property ((!dev_sda_oe_n && scl) |-> ctl_sda_oe_n)
        else $error("controller pulls while target drives");
    a_start_by_ctl: assert property ((scl && $past(scl) && $changed(sda)) |-> $changed(ctl_sda_oe_n))
        else $error("data edge under high clock not from controller");
    a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("target changed data with clock high");
    a_sda_stable_rise: assert property ($rose(scl) |-> $stable(sda) [*2])
        else $error("data moved at clock rise");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
        else $error("clock high phase too short");
    a_scl_low_bound: assert property ($fell(scl) |-> ##[1:16] scl)
        else $error("clock held low too long");
endmodule // blp_link_asserts
`default_nettype wire

// file: testbench/tb_backlight_i2c_register_port.sv
// Bench joining controller and target over one link
`timescale 1ns/1ps
`default_nettype none
module tb_backlight_i2c_register_port;
    import blp_pkg::*;
    logic       clock = 1'b0;
    logic       rst   = 1'b0;
    logic [2:0] addr  = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] sample_in = 8'h00;
    logic [7:0] mean_in   = 8'h00;
    logic [7:0] rdata_r, routing_r, enables_r, wr_index_r, got;
    logic       wr_pulse_r, busy_r;
    int         n_mismatch = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    int         n_pulse = 0;
    blp_link_if link();
    blp_controller #(.QTR_CYC(2)) u_blp_controller (.clock(clock), .rst(rst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r));
    blp_target u_blp_target (.clock(clock), .rst(rst), .link(link), .sample_in(sample_in), .mean_in(mean_in),
        .routing_r(routing_r), .enables_r(enables_r), .wr_index_r(wr_index_r), .wr_pulse_r(wr_pulse_r),
        .busy_r(busy_r));
    blp_link_asserts u_blp_link_asserts (.clock(clock), .rst(rst), .scl(link.scl), .sda(link.sda),
        .ctl_sda_oe_n(link.ctl_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n));
    always #5 clock = ~clock;
    // Cycle ceiling; a full register sweep needs about 15000
    always @(posedge clock)
    begin
        cyc++;
        if (wr_pulse_r === 1'b1)
            n_pulse++;
        if (cyc == 60000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic cw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic cr(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 d = rdata_r;
    endtask
    task automatic reg_op(input logic [7:0] idx, input logic [7:0] dat, input logic [7:0] cmd);
        logic [7:0] s;
        cw(CR_INDEX, idx);
        cw(CR_WDATA, dat);
        cw(CR_CMD, cmd);
        repeat (16) @(posedge clock);
        chk("busy active", 8'h01, {7'h0, busy_r});
        do cr(CR_STATUS, s); while (s[0] !== 1'b0 || s[2] !== 1'b1);
        chk("nack", 8'h00, {7'h0, s[1]});
        cr(CR_RDATA, got);
        repeat (4) @(posedge clock);
        chk("busy", 8'h00, {7'h0, busy_r});
    endtask
    // Write, then read back through a repeated START
    task automatic write_back(input logic [7:0] idx, input logic [7:0] dat, input logic [7:0] exp);
        int n0;
        n0 = n_pulse;
        reg_op(idx, dat, 8'h01);
        chk("pulses", 8'h01, 8'(n_pulse - n0));
        chk("index", idx, wr_index_r);
        reg_op(idx, 8'h00, 8'h02);
        chk("readback", exp, got);
    endtask
    task automatic t_defaults();
        for (int i = 0; i < NREG; i++)
        begin
            reg_op(REG_OFS[i], 8'h00, 8'h02);
            chk("reset value", REG_RST[i], got);
        end
    endtask
    // Asymmetric bit patterns expose a reversed shift order
    task automatic t_rw_regs();
        write_back(OFS_ROUTING, 8'h1E, 8'h1E);
        chk("routing", 8'h1E, routing_r);
        write_back(OFS_ENABLES, 8'h07, 8'h07);
        chk("enables", 8'h07, enables_r);
    endtask
    // Read-only places return live values, writes are dropped
    task automatic t_read_only();
        sample_in <= 8'hC1;
        mean_in   <= 8'h36;
        write_back(OFS_SAMPLE, 8'h55, 8'hC1);
        write_back(OFS_MEAN, 8'hAA, 8'h36);
    endtask
    task automatic t_unmapped();
        write_back(8'h30, 8'h12, 8'h00);
        cr(3'h5, got);
        chk("unmapped cmd reg", 8'h00, got);
    endtask
    initial
    begin
        // A real rising edge clears the link-side flops with async reset
        rst <= 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("routing reset", 8'hE4, routing_r);
        chk("enables reset", 8'hF8, enables_r);
        t_defaults();
        t_rw_regs();
        t_read_only();
        t_unmapped();
        tally_and_finish();
    end
endmodule // tb_backlight_i2c_register_port
`default_nettype wire
